// [acd_decoder.sv]
// Decoder and timer for compare, ASCII/decimal adjust and signed multiply by immediate.
// Assumes instruction bytes come from core logic on the same clock, one per valid.
// How it works
// - First byte 0011100w is a compare that takes an addressing byte and runs 3 clocks on a register or 10 on memory.
// - Byte 00110111 is ASCII adjust after addition, with no addressing byte, running 8 clocks.
// - ASCII adjust after subtraction is a lone byte with no addressing byte and runs 7 clocks.
// - Byte 00101111 is decimal adjust after subtraction, with no addressing byte, running 4 clocks.
// - Pattern 011010s1 is signed multiply by immediate with an addressing byte, one data byte or two when s is 0, 22 or 29 clocks.
`timescale 1ns/1ns
module acd_decoder
  import acd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_byte_valid,
  input  wire logic [7:0] i_byte,
  output logic            o_byte_ready,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_illegal,
  output logic [2:0]      o_op,
  output logic            o_word,
  output logic [1:0]      o_mode,
  output logic [2:0]      o_reg,
  output logic [2:0]      o_rm,
  output logic [15:0]     o_imm
);

  logic       rst_meta;
  logic       rst_sync;
  acd_state_t state;
  acd_op_t    op;
  logic       sext;
  logic       take;
  logic [CNT_W-1:0] busy_len;

  acd_tmr_if tif ();

  acd_timer u_timer (
    .i_clk   (i_clk),
    .i_rst_n (rst_sync),
    .tif     (tif.tmr)
  );

  function automatic acd_op_t decode(input logic [7:0] b);
    if ((b & COMPARE_MASK) == COMPARE_PAT)        return OP_COMPARE;
    else if (b == ASCII_ADD_OPC)                  return OP_ASCII_ADD;
    else if (b == ASCII_SUB_OPC)                  return OP_ASCII_SUB;
    else if (b == DECIMAL_SUB_OPC)                return OP_DECIMAL_SUB;
    else if ((b & SGN_MULT_MASK) == SGN_MULT_PAT) return OP_SGN_MULT;
    else                                          return OP_NONE;
  endfunction : decode

  function automatic logic [CNT_W-1:0] clocks(input acd_op_t o, input logic mem);
    case (o)
      OP_COMPARE:     return mem ? COMPARE_MEM_CLK : COMPARE_REG_CLK;
      OP_ASCII_ADD:   return ASCII_ADD_CLK;
      OP_ASCII_SUB:   return ASCII_SUB_CLK;
      OP_DECIMAL_SUB: return DECIMAL_SUB_CLK;
      OP_SGN_MULT:    return mem ? SGN_MULT_MEM_CLK : SGN_MULT_REG_CLK;
      default:        return 6'h01;
    endcase
  endfunction : clocks

  // Reset enters asynchronously but is released on the clock
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign take   = i_byte_valid && o_byte_ready;
  assign o_op   = op;

  // Busy stretch kept as a count, since a long repetition would not unroll
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      busy_len <= '0;
    end else if (o_busy) begin
      busy_len <= busy_len + 6'h01;
    end else begin
      busy_len <= '0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state        <= ST_IDLE;
      op           <= OP_NONE;
      sext         <= 1'b0;
      o_byte_ready <= 1'b0;
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_illegal    <= 1'b0;
      o_word       <= 1'b0;
      o_mode       <= 2'h0;
      o_reg        <= 3'h0;
      o_rm         <= 3'h0;
      o_imm        <= 16'h0000;
      tif.start    <= 1'b0;
      tif.load     <= '0;
    end else begin
      tif.start <= 1'b0;
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_byte_ready <= 1'b1;
          if (take) begin
            op     <= decode(i_byte);
            sext   <= i_byte[S_BIT];
            o_word <= (decode(i_byte) == OP_COMPARE) ? i_byte[W_BIT] : (decode(i_byte) == OP_SGN_MULT);
            o_mode <= MODE_REG;
            o_imm  <= 16'h0000;
            if (decode(i_byte) == OP_NONE) begin
              o_illegal <= 1'b1;
            end else if (decode(i_byte) == OP_COMPARE || decode(i_byte) == OP_SGN_MULT) begin
              state <= ST_MODRM;
            end else begin
              // Adjusts need no addressing byte
              state        <= ST_EXEC;
              tif.start    <= 1'b1;
              tif.load     <= clocks(decode(i_byte), 1'b0);
              o_busy       <= 1'b1;
              o_byte_ready <= 1'b0;
            end
          end
        end
        ST_MODRM: begin
          if (take) begin
            o_mode <= i_byte[MODE_HI:MODE_LO];
            o_reg  <= i_byte[REG_HI:REG_LO];
            o_rm   <= i_byte[RM_HI:RM_LO];
            if (op == OP_SGN_MULT) begin
              state <= ST_IMM_LO;
            end else begin
              state        <= ST_EXEC;
              o_busy       <= 1'b1;
              tif.start    <= 1'b1;
              tif.load     <= clocks(op, i_byte[MODE_HI:MODE_LO] != MODE_REG);
              o_byte_ready <= 1'b0;
            end
          end
        end
        ST_IMM_LO: begin
          if (take) begin
            o_imm <= sext ? {{8{i_byte[7]}}, i_byte} : {8'h00, i_byte};
            if (sext) begin
              state        <= ST_EXEC;
              o_busy       <= 1'b1;
              tif.start    <= 1'b1;
              tif.load     <= clocks(op, o_mode != MODE_REG);
              o_byte_ready <= 1'b0;
            end else begin
              state <= ST_IMM_HI;
            end
          end
        end
        ST_IMM_HI: begin
          if (take) begin
            o_imm[15:8]  <= i_byte;
            o_busy       <= 1'b1;
            state        <= ST_EXEC;
            tif.start    <= 1'b1;
            tif.load     <= clocks(op, o_mode != MODE_REG);
            o_byte_ready <= 1'b0;
          end
        end
        ST_EXEC: begin
          // Bytes are held off while executing; no prefetch queue here
          if (tif.done) begin
            o_done       <= 1'b1;
            o_busy       <= 1'b0;
            state        <= ST_IDLE;
            o_byte_ready <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_sync);

  a_compare_reg_time: assert property (tif.start && op == OP_COMPARE && o_mode == MODE_REG
    |-> ##3 tif.done ##1 o_done)
    else $error("compare on register not 3 clocks");
  a_compare_mem_time: assert property (tif.start && op == OP_COMPARE && o_mode != MODE_REG
    |=> !tif.done [*8] ##1 !tif.done ##1 tif.done)
    else $error("compare on memory not 10 clocks");
  a_ascii_add_time: assert property (tif.start && op == OP_ASCII_ADD
    |-> ##8 o_busy && tif.done)
    else $error("ascii add adjust not 8 clocks");
  a_ascii_sub_time: assert property (tif.start && op == OP_ASCII_SUB
    |-> o_busy [*8] ##1 o_done)
    else $error("ascii sub adjust not 7 clocks");
  a_decimal_sub_time: assert property (tif.start && op == OP_DECIMAL_SUB
    |-> ##4 tif.done ##1 (o_done && !o_busy))
    else $error("decimal sub adjust not 4 clocks");
  a_mult_reg_load: assert property (tif.start && op == OP_SGN_MULT && o_mode == MODE_REG
    |-> tif.load == SGN_MULT_REG_CLK)
    else $error("signed multiply register time wrong");
  a_mult_reg_time: assert property (o_done && op == OP_SGN_MULT && o_mode == MODE_REG
    |-> busy_len == SGN_MULT_REG_CLK + 6'h01)
    else $error("signed multiply on register ran the wrong length");
  a_mult_mem_time: assert property (o_done && op == OP_SGN_MULT && o_mode != MODE_REG
    |-> busy_len == SGN_MULT_MEM_CLK + 6'h01)
    else $error("signed multiply on memory ran the wrong length");
  a_mult_sext_bytes: assert property (state == ST_IMM_LO && take && sext
    |=> state == ST_EXEC && tif.start)
    else $error("sign-extended immediate took a second byte");
  a_mult_two_bytes: assert property (state == ST_IMM_LO && take && !sext
    |=> state == ST_IMM_HI && !tif.start)
    else $error("word immediate missed its high byte");
  a_word_select: assert property (state == ST_IDLE && take && decode(i_byte) == OP_COMPARE
    |=> o_word == $past(i_byte[0]))
    else $error("width bit not applied");
  a_no_modrm_adjust: assert property (state == ST_IDLE && take &&
    decode(i_byte) inside {OP_ASCII_ADD, OP_ASCII_SUB, OP_DECIMAL_SUB} |=> state == ST_EXEC && !o_byte_ready)
    else $error("adjust waited for an addressing byte");

  c_compare_mem: cover property (tif.start && op == OP_COMPARE && o_mode != MODE_REG);
  c_mult_word_imm: cover property (state == ST_IMM_HI && take);
  c_mult_mem_done: cover property (o_done && op == OP_SGN_MULT && o_mode != MODE_REG);
  c_ascii_add_done: cover property (o_done && op == OP_ASCII_ADD);
  c_illegal: cover property (o_illegal);

endmodule : acd_decoder

// [acd_pkg.sv]
// Package for the arithmetic compare and adjust decoder: opcodes, field positions,
// operation codes, states and clock counts.
// Assumes nothing beyond a SystemVerilog compiler.
package acd_pkg;

  localparam int unsigned CNT_W = 6;

  // First-byte patterns and the bits that must match them
  localparam logic [7:0] COMPARE_PAT     = 8'h38;
  localparam logic [7:0] COMPARE_MASK    = 8'hFE;
  localparam logic [7:0] ASCII_ADD_OPC   = 8'h37;
  localparam logic [7:0] ASCII_SUB_OPC   = 8'h3F;
  localparam logic [7:0] DECIMAL_SUB_OPC = 8'h2F;
  localparam logic [7:0] SGN_MULT_PAT    = 8'h69;
  localparam logic [7:0] SGN_MULT_MASK   = 8'hFD;

  // Field positions in the first byte and the addressing byte
  localparam int unsigned W_BIT    = 0;
  localparam int unsigned S_BIT    = 1;
  localparam int unsigned MODE_HI  = 7;
  localparam int unsigned MODE_LO  = 6;
  localparam int unsigned REG_HI   = 5;
  localparam int unsigned REG_LO   = 3;
  localparam int unsigned RM_HI    = 2;
  localparam int unsigned RM_LO    = 0;
  localparam logic [1:0]  MODE_REG = 2'h3;

  // Clock counts per operation
  localparam logic [CNT_W-1:0] COMPARE_REG_CLK  = 6'h03;
  localparam logic [CNT_W-1:0] COMPARE_MEM_CLK  = 6'h0A;
  localparam logic [CNT_W-1:0] ASCII_ADD_CLK    = 6'h08;
  localparam logic [CNT_W-1:0] ASCII_SUB_CLK    = 6'h07;
  localparam logic [CNT_W-1:0] DECIMAL_SUB_CLK  = 6'h04;
  localparam logic [CNT_W-1:0] SGN_MULT_REG_CLK = 6'h16;
  localparam logic [CNT_W-1:0] SGN_MULT_MEM_CLK = 6'h1D;

  typedef enum logic [2:0] {
    OP_NONE        = 3'h0,
    OP_COMPARE     = 3'h1,
    OP_ASCII_ADD   = 3'h2,
    OP_ASCII_SUB   = 3'h3,
    OP_DECIMAL_SUB = 3'h4,
    OP_SGN_MULT    = 3'h5
  } acd_op_t;

  // Gray codes along the fetch path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_MODRM  = 3'h1,
    ST_IMM_LO = 3'h3,
    ST_IMM_HI = 3'h2,
    ST_EXEC   = 3'h6
  } acd_state_t;

endpackage : acd_pkg

// [acd_tmr_if.sv]
// Carrier between the decoder control and its execution timer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface acd_tmr_if;
  import acd_pkg::*;
  logic             start;
  logic [CNT_W-1:0] load;
  logic             done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface : acd_tmr_if

// [acd_timer.sv]
// Execution timer: counts the clocks of one decoded operation.
// Assumes a synchronised active-low reset and a load of at least one.
`timescale 1ns/1ns
module acd_timer
  import acd_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  acd_tmr_if.tmr    tif
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
    end else if (tif.start) begin
      count <= tif.load;
    end else if (count != '0) begin
      count <= count - 6'h01;
    end
  end

  // Done in the last counted clock; the caller's busy still lasts one clock more than the load
  assign tif.done = (count == 6'h01);

endmodule : acd_timer

// [arith_compare_adjust_decode_test.sv]
// Self-checking bench for the compare, adjust and multiply decoder.
// Assumes acd_pkg and acd_decoder are compiled first; no partner model.
`timescale 1ns/1ns
module arith_compare_adjust_decode_test;
  import acd_pkg::*;

  typedef struct packed {
    logic             ill;
    logic [2:0]       op;
    logic             word;
    logic [1:0]       mode;
    logic [2:0]       rg;
    logic [2:0]       rm;
    logic [15:0]      imm;
    logic [CNT_W-1:0] n;
  } acd_exp_t;

  logic        i_clk;
  logic        i_reset_n;
  logic        i_byte_valid;
  logic [7:0]  i_byte;
  logic        o_byte_ready;
  logic        o_busy;
  logic        o_done;
  logic        o_illegal;
  logic [2:0]  o_op;
  logic        o_word;
  logic [1:0]  o_mode;
  logic [2:0]  o_reg;
  logic [2:0]  o_rm;
  logic [15:0] o_imm;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          bcnt      = 0;
  logic [2:0]  last_rg   = 3'h0;
  logic [2:0]  last_rm   = 3'h0;
  acd_exp_t    q[$];

  acd_decoder dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
    .o_byte_ready(o_byte_ready), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_op(o_op),
    .o_word(o_word), .o_mode(o_mode), .o_reg(o_reg), .o_rm(o_rm), .o_imm(o_imm));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic bit legal(input logic [7:0] b);
    return ((b & COMPARE_MASK) == COMPARE_PAT) || b == ASCII_ADD_OPC || b == ASCII_SUB_OPC ||
           b == DECIMAL_SUB_OPC || ((b & SGN_MULT_MASK) == SGN_MULT_PAT);
  endfunction : legal

  // Holds the byte until the edge where ready is high
  task automatic send(input logic [7:0] b);
    int k;
    @(negedge i_clk);
    i_byte_valid = 1'b1;
    i_byte       = b;
    k = 0;
    while (o_byte_ready !== 1'b1 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 200) begin
      bad_count++;
      stop_test();
    end
  endtask : send

  task automatic run(input int kind);
    logic [7:0] b;
    logic [7:0] m;
    logic [7:0] lo;
    logic [7:0] hi;
    acd_exp_t   e;
    b = 8'($urandom);
    m = 8'($urandom);
    lo = 8'($urandom);
    hi = 8'($urandom);
    e = '0;
    e.mode = MODE_REG;
    e.rg = last_rg;
    e.rm = last_rm;
    case (kind)
      0: begin
        b = {COMPARE_PAT[7:1], b[0]};
        e.op = OP_COMPARE;
        e.word = b[0];
      end
      1: begin
        b = ASCII_ADD_OPC;
        e.op = OP_ASCII_ADD;
        e.n = ASCII_ADD_CLK;
      end
      2: begin
        b = ASCII_SUB_OPC;
        e.op = OP_ASCII_SUB;
        e.n = ASCII_SUB_CLK;
      end
      3: begin
        b = DECIMAL_SUB_OPC;
        e.op = OP_DECIMAL_SUB;
        e.n = DECIMAL_SUB_CLK;
      end
      4: begin
        b = {SGN_MULT_PAT[7:2], b[1], 1'b1};
        e.op = OP_SGN_MULT;
        e.word = 1'b1;
        e.imm = b[1] ? {{8{lo[7]}}, lo} : {hi, lo};
      end
      default: begin while (legal(b)) b = 8'($urandom); e.ill = 1'b1; end
    endcase
    if (kind == 0 || kind == 4) begin
      {e.mode, e.rg, e.rm} = m;
      last_rg = m[5:3];
      last_rm = m[2:0];
      if (kind == 0) e.n = (m[7:6] == MODE_REG) ? COMPARE_REG_CLK : COMPARE_MEM_CLK;
      else e.n = (m[7:6] == MODE_REG) ? SGN_MULT_REG_CLK : SGN_MULT_MEM_CLK;
    end
    q.push_back(e);
    send(b);
    if (kind == 0 || kind == 4) send(m);
    if (kind == 4) send(lo);
    if (kind == 4 && !b[1]) send(hi);
    // Junk offered while ready is low must be refused
    if (kind < 5) repeat (3) begin
      @(negedge i_clk);
      i_byte = 8'($urandom);
    end
    @(negedge i_clk);
    i_byte_valid = 1'b0;
  endtask : run

  always @(negedge i_clk) begin : mon
    acd_exp_t e;
    if (o_busy === 1'b1) bcnt++;
    if (o_done === 1'b1 || o_illegal === 1'b1) begin
      if (q.size() == 0) chk(16'h1, 16'h0);
      else begin
        e = q.pop_front();
        chk({15'h0, o_illegal}, {15'h0, e.ill});
        if (!e.ill) begin
          chk({13'h0, o_op}, {13'h0, e.op});
          chk({15'h0, o_word}, {15'h0, e.word});
          chk({8'h0, o_mode, o_reg, o_rm}, {8'h0, e.mode, e.rg, e.rm});
          chk(o_imm, e.imm);
          chk(16'(bcnt), 16'(e.n) + 16'h1);
        end
      end
      bcnt = 0;
    end
  end

  initial begin
    repeat (50000) @(posedge i_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    int k;
    i_reset_n = 1'b0;
    i_byte_valid = 1'b0;
    i_byte = 8'h00;
    void'($urandom(27));
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_reset_n = 1'b1;
    for (k = 0; k < 6; k++) run(k);
    $display("Directed test done");
    repeat (40) run(int'($urandom % 6));
    $display("Random test done");
    k = 0;
    while (q.size() > 0 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    if (q.size() > 0) bad_count++;
    stop_test();
  end
endmodule : arith_compare_adjust_decode_test
